// >>> pwm_timing_parameter_regs.sv
`timescale 1ns/1ns
`include "pwm_timing_params.svh"
module pwm_timing_parameter_regs
  import pwm_timing_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pwm_out,
  output logic pwm_out_n,
  output logic blanking,
  output logic period_event,
  output logic [3:0] event_phase
);
  typedef struct packed {
    logic [7:0] period_low_byte;
    logic [7:0] period_high_byte;
    logic [7:0] rising_dead_time;
    logic [7:0] falling_dead_time;
    logic [7:0] fractional_period_adjust;
    logic [7:0] rising_blank_time;
    logic [31:0] rdata;
    logic err;
    logic rdy;
    logic pwm;
    logic lo_on;
    logic hi_on;
    logic blank;
    logic [7:0] dcnt;
    logic [7:0] bcnt;
    phase_e ph;
  } st_s;
  st_s r;
  st_s n;
  logic [15:0] period_value;
  logic evt_pre;
  logic [3:0] ph_pre;
  logic acc;
  logic hit;
  logic [31:0] rd;

  assign period_value = {r.period_high_byte, r.period_low_byte};

  pwm_edge_timer #(.W(16)) timer (
    .pclk(pclk),
    .presetn(presetn),
    .period_value(period_value),
    .frac(r.fractional_period_adjust[3:0]),
    .period_event(evt_pre),
    .event_phase(ph_pre)
  );

  always_comb begin
    n = r;
    acc = psel && penable;
    hit = 1'b1;
    rd = `READ_ZERO;
    case (paddr)
      `OFS_PERIOD_LOW: rd[7:0] = r.period_low_byte;
      `OFS_PERIOD_HIGH: rd[7:0] = r.period_high_byte;
      `OFS_RISE_DEAD: rd[7:0] = r.rising_dead_time;
      `OFS_FALL_DEAD: rd[7:0] = r.falling_dead_time;
      `OFS_FRAC_ADJ: rd[7:0] = r.fractional_period_adjust & `FRAC_MASK;
      `OFS_RISE_BLANK: rd[7:0] = r.rising_blank_time;
      `OFS_STATUS: rd[3:0] = {r.blank, r.hi_on, r.lo_on, r.pwm};
      default: hit = 1'b0;
    endcase
    // One wait state: answer in the access phase's second cycle
    n.rdy = acc && !r.rdy;
    n.err = acc && !r.rdy && !hit;
    n.rdata = (acc && !r.rdy && !pwrite) ? rd : `READ_ZERO;
    // Write lands on the edge that samples pready high, as the master sees it
    if (acc && r.rdy && pwrite) begin
      case (paddr)
        `OFS_PERIOD_LOW: n.period_low_byte = pwdata[7:0];
        `OFS_PERIOD_HIGH: n.period_high_byte = pwdata[7:0];
        `OFS_RISE_DEAD: n.rising_dead_time = pwdata[7:0];
        `OFS_FALL_DEAD: n.falling_dead_time = pwdata[7:0];
        `OFS_FRAC_ADJ: begin
          n.fractional_period_adjust = pwdata[7:0] & `FRAC_MASK;
        end
        `OFS_RISE_BLANK: n.rising_blank_time = pwdata[7:0];
        default: ;
      endcase
    end
    case (r.ph)
      ph_idle: begin
        n.lo_on = 1'b1;
        n.hi_on = 1'b0;
        if (evt_pre) begin
          n.lo_on = 1'b0;
          // Load edge is itself the first dead clock, so load one less
          n.dcnt = r.rising_dead_time - `COUNT_STEP;
          n.ph = ph_dead;
          if (r.rising_dead_time == `COUNT_DONE) begin
            n.hi_on = 1'b1;
            n.blank = r.rising_blank_time != `COUNT_DONE;
            n.bcnt = r.rising_blank_time - `COUNT_STEP;
            n.ph = ph_on;
          end
        end
      end
      ph_dead: begin
        if (r.dcnt == `COUNT_DONE) begin
          n.hi_on = 1'b1;
          n.blank = r.rising_blank_time != `COUNT_DONE;
          n.bcnt = r.rising_blank_time - `COUNT_STEP;
          n.ph = ph_on;
        end else begin
          n.dcnt = r.dcnt - `COUNT_STEP;
        end
      end
      ph_on: begin
        if (r.bcnt != `COUNT_DONE) begin
          n.bcnt = r.bcnt - `COUNT_STEP;
        end else begin
          n.blank = 1'b0;
        end
        if (evt_pre) begin
          // Blanking never outlives the high-side pulse
          n.hi_on = 1'b0;
          n.blank = 1'b0;
          n.dcnt = r.falling_dead_time - `COUNT_STEP;
          n.ph = ph_blank;
          if (r.falling_dead_time == `COUNT_DONE) begin
            n.lo_on = 1'b1;
            n.ph = ph_idle;
          end
        end
      end
      ph_blank: begin
        n.blank = 1'b0;
        if (r.dcnt == `COUNT_DONE) begin
          n.lo_on = 1'b1;
          n.ph = ph_idle;
        end else begin
          n.dcnt = r.dcnt - `COUNT_STEP;
        end
      end
      default: n.ph = ph_idle;
    endcase
    // Status bit 0 mirrors the high-side drive
    n.pwm = n.hi_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Delayed copy so every output leaves a flip-flop
  logic evt_q;
  logic [3:0] ph_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 1'b0;
      ph_q <= 4'h0;
    end else begin
      evt_q <= evt_pre;
      ph_q <= ph_pre;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.rdy;
  assign pslverr = r.err;
  assign pwm_out = r.hi_on;
  assign pwm_out_n = r.lo_on;
  assign blanking = r.blank;
  assign period_event = evt_q;
  assign event_phase = ph_q;
endmodule

// >>> pwm_timing_params.svh
// Overview of operation
// - Period value bits 7:0 are the low byte, 15:8 the high byte.
// - Rising dead time counts PWM clocks of dead band at the rising edge.
// - Falling dead time counts PWM clocks of dead band at the falling edge.
// - The 4-bit fraction accumulates at every period event; each carry adds one clock to the next period.
// - One fractional unit is one sixteenth of a PWM clock period.
// - Rising blank time counts PWM clocks of rising-edge blanking.
// - Upper four bits of the fraction register ignore writes, read zero.
// - All implemented bits reset to zero on every reset; all but the status bits are read/write.
`ifndef PWM_TIMING_PARAMS_SVH
`define PWM_TIMING_PARAMS_SVH
`define OFS_PERIOD_LOW 12'h000
`define OFS_PERIOD_HIGH 12'h004
`define OFS_RISE_DEAD 12'h008
`define OFS_FALL_DEAD 12'h00C
`define OFS_FRAC_ADJ 12'h010
`define OFS_RISE_BLANK 12'h014
`define OFS_STATUS 12'h018
`define RESET_BYTE 8'h00
`define FRAC_MASK 8'h0F
`define FRAC_STEPS 5'h10
`define COUNT_DONE 8'h00
`define COUNT_STEP 8'h01
`define READ_ZERO 32'h0000_0000
`endif

// >>> pwm_timing_pkg.sv
package pwm_timing_pkg;
  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_dead = 2'b01,
    ph_on = 2'b11,
    ph_blank = 2'b10
  } phase_e;
endpackage

// >>> pwm_edge_timer.sv
`timescale 1ns/1ns
`include "pwm_timing_params.svh"
module pwm_edge_timer
  import pwm_timing_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] period_value,
  input wire logic [3:0] frac,
  output logic period_event,
  output logic [3:0] event_phase
);
  typedef struct packed {
    logic [W-1:0] count;
    logic [4:0] acc;
    logic stretch;
    logic evt;
    logic [3:0] ph;
  } st_s;
  st_s r;
  st_s n;
  logic [4:0] sum;
  always_comb begin
    n = r;
    n.evt = 1'b0;
    sum = {1'b0, r.acc[3:0]} + {1'b0, frac};
    if (r.stretch) begin
      n.stretch = 1'b0;
      n.count = '0;
    end else if (r.count >= period_value) begin
      // Carry out of sixteenths stretches one clock: average period grows
      n.evt = 1'b1;
      n.ph = r.acc[3:0];
      n.acc = sum;
      n.stretch = sum >= `FRAC_STEPS;
      n.acc[4] = 1'b0;
      n.count = '0;
    end else begin
      n.count = r.count + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign period_event = r.evt;
  assign event_phase = r.ph;
endmodule

// >>> pwm_regs_chk_sva.sv
`timescale 1ns/1ns
module pwm_regs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_out,
  input wire logic pwm_out_n,
  input wire logic blanking,
  input wire logic period_event,
  input wire logic [3:0] event_phase
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence taken;
    psel && penable && !pready;
  endsequence
  sequence frac_read;
    pready && !pwrite && paddr == 12'h010;
  endsequence
  chk_one_wait: assert property (taken |=> pready)
    else $error("ready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  chk_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_frac_upper: assert property (frac_read |-> prdata[31:4] == 0)
    else $error("fraction upper bits set");
  chk_err_pair: assert property (pslverr |-> pready && prdata == 0)
    else $error("error without answer");
  chk_no_overlap: assert property (!(pwm_out && pwm_out_n))
    else $error("both drives on");
  chk_phase_hold: assert property (
    !period_event |-> $stable(event_phase))
    else $error("phase moved without event");
  chk_blank_high: assert property (blanking |-> pwm_out)
    else $error("blanking while high side off");
endmodule
bind pwm_timing_parameter_regs pwm_regs_chk u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_out(pwm_out), .pwm_out_n(pwm_out_n), .blanking(blanking),
  .period_event(period_event), .event_phase(event_phase));

// >>> pwm_timing_parameter_regs_tb.sv
`timescale 1ns/1ns
module pwm_timing_parameter_regs_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, pwm_out, pwm_out_n, blanking, period_event, e;
  logic [3:0] event_phase;
  int mismatches = 0, check_count = 0, cyc = 0;
  pwm_timing_parameter_regs dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_out(pwm_out), .pwm_out_n(pwm_out_n),
    .blanking(blanking), .period_event(period_event),
    .event_phase(event_phase));
  initial forever #50 pclk = ~pclk;
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard: whole run needs well under this many cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      print_verdict();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One idle edge after each transfer so psel is never set twice at once
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wait_ev;
    do @(posedge pclk); while (period_event !== 1'b1);
  endtask
  // Counts clocks, both-off clocks and blanking clocks over k periods
  task per(input int k, input int len, input int gap, input int blk);
    int n, g, b;
    n = 0;
    g = 0;
    b = 0;
    wait_ev();
    wait_ev();
    repeat (k) begin
      do begin
        @(posedge pclk);
        n++;
        g += int'(!pwm_out && !pwm_out_n);
        b += int'(blanking);
      end while (period_event !== 1'b1);
    end
    chk(n, len);
    chk(g, gap);
    chk(b, blk);
  endtask
  // Two events in a row: phases are 0 and 8 in either order, so their sum is eight
  task phase_test;
    logic [3:0] a;
    wait_ev();
    a = event_phase;
    wait_ev();
    chk(32'(a) + 32'(event_phase), 32'h8);
  endtask
  task regs_test;
    for (int i = 0; i < 6; i++) begin
      apb(0, 12'(i * 4), 0);
      chk(r, 0);
      apb(1, 12'(i * 4), 32'hFFFFFFA5);
      apb(0, 12'(i * 4), 0);
      chk(r, (i == 4) ? 32'h5 : 32'hA5);
    end
    apb(0, 12'h01C, 0);
    chk({31'h0, e}, 1);
    chk(r, 0);
    apb(1, 12'h01C, 32'hFF);
    chk({31'h0, e}, 1);
    apb(0, 12'h018, 0);
    chk(r & 32'hFFFF_FFF0, 0);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    regs_test();
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h000, 0);
    chk(r, 0);
    apb(1, 12'h008, 32'h3);
    apb(1, 12'h00C, 32'h5);
    apb(1, 12'h014, 32'h4);
    apb(1, 12'h000, 32'h27);
    // High and low phases alternate per event: judge two periods at a time
    per(2, 80, 8, 4);
    apb(1, 12'h004, 32'h1);
    apb(1, 12'h000, 32'h0);
    per(2, 514, 8, 4);
    apb(1, 12'h004, 32'h0);
    apb(1, 12'h000, 32'h27);
    apb(1, 12'h010, 32'h8);
    per(16, 648, 64, 32);
    phase_test();
    print_verdict();
  end
endmodule
